/* File: rtl/dma_stat_pkg.sv */
// constants for the dma status, interrupt-clear and software request block
// assumes a 32-bit register port with byte addresses
package dma_stat_pkg;
  localparam int unsigned NUM_CH  = 2;
  localparam int unsigned NUM_SRC = 5;
  // register byte addresses
  localparam logic [31:0] ADDR_COMBINED   = 32'hFFE04000;
  localparam logic [31:0] ADDR_TC_MASKED  = 32'hFFE04004;
  localparam logic [31:0] ADDR_TC_CLEAR   = 32'hFFE04008;
  localparam logic [31:0] ADDR_ERR_MASKED = 32'hFFE0400C;
  localparam logic [31:0] ADDR_ERR_CLEAR  = 32'hFFE04010;
  localparam logic [31:0] ADDR_TC_RAW     = 32'hFFE04014;
  localparam logic [31:0] ADDR_ERR_RAW    = 32'hFFE04018;
  localparam logic [31:0] ADDR_ENABLED    = 32'hFFE0401C;
  localparam logic [31:0] ADDR_SOFT_BREQ  = 32'hFFE04020;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'hFFE04040;
  localparam logic [31:0] ADDR_IRQ_STAT   = 32'hFFE04044;
  localparam logic [31:0] ADDR_CH_ENABLE  = 32'hFFE04048;
  // burst request source bits
  localparam int unsigned SRC_SERIAL0_TX  = 0;
  localparam int unsigned SRC_SERIAL0_RX  = 1;
  localparam int unsigned SRC_SERIAL1_TX  = 2;
  localparam int unsigned SRC_SERIAL1_RX  = 3;
  localparam int unsigned SRC_MEMORY_CARD = 4;
  // block interrupt event bits
  localparam int unsigned EV_TC  = 0;
  localparam int unsigned EV_ERR = 1;
  localparam int unsigned EV_W   = 2;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h00000000;
endpackage

/* File: rtl/sticky_flags.sv */
// per-bit sticky flags: set by hardware events, cleared by a write of ones
// set wins over clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module sticky_flags #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);
  initial
  begin
    if (W < 1) $error("sticky_flags: width must be at least one");
  end

  // one flop per bit, each with its own variable so no two processes share one
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic flag_q;

    always_ff @(posedge clk)
    begin
      if (!nrst)
        flag_q <= 1'b0;
      else if (set[i])
        flag_q <= 1'b1;
      else if (clr[i])
        flag_q <= 1'b0;
    end

    assign flags[i] = flag_q;
  end
endmodule
`default_nettype wire

/* File: rtl/soft_burst_req.sv */
// software burst request flags, one per source, cleared on completion
// expects done pulses from the transfer engine
`timescale 1ns/10ps
`default_nettype none
module soft_burst_req #(
  parameter int unsigned N = 5
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [N-1:0] sw_set,
  input  wire logic [N-1:0] done,
  input  wire logic [N-1:0] periph_req,
  output logic      [N-1:0] sw_flags,
  output logic      [N-1:0] req_out
);
  initial
  begin
    if (N < 1) $error("soft_burst_req: need at least one source");
  end

  // a one raises the request, a zero does nothing, completion clears
  always_ff @(posedge clk)
  begin
    if (!nrst)
      sw_flags <= '0;
    else
      sw_flags <= sw_set | (sw_flags & ~done);
  end

  // request from either peripheral line or software flag
  assign req_out = sw_flags | periph_req;
endmodule
`default_nettype wire

/* File: rtl/dma_irq_status.sv */
// dma status, interrupt clear and software burst request registers
// assumes a transfer engine that pulses per-channel events and done signals
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
// How it works
// [R1] tc clear write ones clear raw tc
// [R2] error clear write ones clear raw error
// [R3] error masked status read-only, resets zero
// [R4] raw tc status shows unmasked request
// [R5] raw error status shows unmasked request
// [R6] enabled channels mirrors channel enable bits
// [R7] transfer completion clears channel enable
// [R8] writing one raises software burst request
// [R9] completion clears software burst request bit
// [R10] writing zero leaves request bits alone
// [R11] read returns sources currently requesting burst
// [R12] bits map serial0 tx/rx, serial1 tx/rx, card
// [R13] request from peripheral line or software
// [R14] software avoids mixing software and hardware requests
// [R15] reserved bits written zero, read zero here
// [R16] tc masked status read-only, resets zero
// [R17] combined status ors masked error and tc
// [R18] masked equals raw and channel mask
module dma_irq_status (
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic [31:0] ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic [1:0]  TC_EVENT,
  input  wire logic [1:0]  ERR_EVENT,
  input  wire logic [1:0]  CH_DONE,
  input  wire logic [1:0]  TC_MASK,
  input  wire logic [1:0]  ERR_MASK,
  input  wire logic [4:0]  PERIPH_BREQ,
  input  wire logic [4:0]  SRC_DONE,
  output logic      [4:0]  BURST_REQ,
  output logic      [1:0]  CH_ENABLE,
  output logic             IRQ
);
  localparam int unsigned NC = dma_stat_pkg::NUM_CH;
  localparam int unsigned NS = dma_stat_pkg::NUM_SRC;
  localparam int unsigned NE = dma_stat_pkg::EV_W;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [NC-1:0] tc_raw_status;
  logic [NC-1:0] error_raw_status;
  logic [NC-1:0] tc_status_masked;
  logic [NC-1:0] error_status_masked;
  logic [NC-1:0] combined_irq_status;
  logic [NC-1:0] enabled_channel_status;
  logic [NS-1:0] software_burst_request;
  logic [NC-1:0] tc_clear_port;
  logic [NC-1:0] error_clear_port;
  logic [NS-1:0] sw_set;
  logic [NE-1:0] irq_mask_q;
  logic [NE-1:0] irq_stat;
  logic [NE-1:0] irq_stat_clr;
  logic [NE-1:0] irq_events;
  logic [NC-1:0] ch_enable_q;
  logic [31:0]   rdata_d;
  logic [31:0]   rdata_q;
  logic          wr_tc_clr;
  logic          wr_err_clr;
  logic          wr_soft;
  logic          wr_mask;
  logic          wr_stat;
  logic          wr_chen;

  // write strobes per register
  assign wr_tc_clr  = WR && (ADDR == dma_stat_pkg::ADDR_TC_CLEAR);
  assign wr_err_clr = WR && (ADDR == dma_stat_pkg::ADDR_ERR_CLEAR);
  assign wr_soft    = WR && (ADDR == dma_stat_pkg::ADDR_SOFT_BREQ);
  assign wr_mask    = WR && (ADDR == dma_stat_pkg::ADDR_IRQ_MASK);
  assign wr_stat    = WR && (ADDR == dma_stat_pkg::ADDR_IRQ_STAT);
  assign wr_chen    = WR && (ADDR == dma_stat_pkg::ADDR_CH_ENABLE);

  // ----------------------------------------------------------------
  // raw interrupt status
  // ----------------------------------------------------------------
  // only ones in the written word clear a bit
  assign tc_clear_port    = wr_tc_clr ? WDATA[NC-1:0] : '0;  // [R1]
  assign error_clear_port = wr_err_clr ? WDATA[NC-1:0] : '0; // [R2]

  // terminal count requests before masking
  sticky_flags #(.W(NC)) u_tc_raw (
    .clk   (CLK_SYS),
    .nrst  (NRST),
    .set   (TC_EVENT),
    .clr   (tc_clear_port),
    .flags (tc_raw_status)                                   // [R4]
  );

  // error requests before masking
  sticky_flags #(.W(NC)) u_err_raw (
    .clk   (CLK_SYS),
    .nrst  (NRST),
    .set   (ERR_EVENT),
    .clr   (error_clear_port),
    .flags (error_raw_status)                                // [R5]
  );

  // ----------------------------------------------------------------
  // masked and combined status
  // ----------------------------------------------------------------
  // mask comes from the channel configuration outside
  assign tc_status_masked    = tc_raw_status & TC_MASK;      // [R18] [R16]
  assign error_status_masked = error_raw_status & ERR_MASK;  // [R18] [R3]
  assign combined_irq_status = tc_status_masked | error_status_masked; // [R17]

  // ----------------------------------------------------------------
  // channel enables
  // ----------------------------------------------------------------
  // software sets enable, completion clears it, completion wins
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      ch_enable_q <= '0;
    else if (wr_chen)
      ch_enable_q <= WDATA[NC-1:0] & ~CH_DONE;               // [R7]
    else
      ch_enable_q <= ch_enable_q & ~CH_DONE;                 // [R7]
  end

  assign enabled_channel_status = ch_enable_q;               // [R6]
  assign CH_ENABLE              = ch_enable_q;

  // ----------------------------------------------------------------
  // software burst requests
  // ----------------------------------------------------------------
  // reserved upper bits are ignored on write
  assign sw_set = wr_soft ? WDATA[NS-1:0] : '0;              // [R8] [R10] [R15]

  // bit order: serial0 tx, serial0 rx, serial1 tx, serial1 rx, card
  soft_burst_req #(.N(NS)) u_soft (
    .clk        (CLK_SYS),
    .nrst       (NRST),
    .sw_set     (sw_set),                                    // [R12]
    .done       (SRC_DONE),                                  // [R9]
    .periph_req (PERIPH_BREQ),
    .sw_flags   (),
    .req_out    (software_burst_request)                     // [R13] [R11]
  );

  // sources may be driven by both; software is asked not to [R14]
  assign BURST_REQ = software_burst_request;

  // ----------------------------------------------------------------
  // block interrupt
  // ----------------------------------------------------------------
  // any new terminal count or error event latches a sticky bit
  assign irq_events[dma_stat_pkg::EV_TC]  = |TC_EVENT;
  assign irq_events[dma_stat_pkg::EV_ERR] = |ERR_EVENT;
  assign irq_stat_clr = wr_stat ? WDATA[NE-1:0] : '0;

  sticky_flags #(.W(NE)) u_irq (
    .clk   (CLK_SYS),
    .nrst  (NRST),
    .set   (irq_events),
    .clr   (irq_stat_clr),
    .flags (irq_stat)
  );

  // mask register
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      irq_mask_q <= '0;
    else if (wr_mask)
      irq_mask_q <= WDATA[NE-1:0];
  end

  // level output while an unmasked bit stands
  assign IRQ = |(irq_stat & irq_mask_q);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // reserved and unmapped bits read as zero
  always_comb
  begin
    rdata_d = dma_stat_pkg::RST_ZERO;
    case (ADDR)
      dma_stat_pkg::ADDR_COMBINED:   rdata_d[NC-1:0] = combined_irq_status;
      dma_stat_pkg::ADDR_TC_MASKED:  rdata_d[NC-1:0] = tc_status_masked;    // [R16]
      dma_stat_pkg::ADDR_ERR_MASKED: rdata_d[NC-1:0] = error_status_masked; // [R3]
      dma_stat_pkg::ADDR_TC_RAW:     rdata_d[NC-1:0] = tc_raw_status;       // [R4]
      dma_stat_pkg::ADDR_ERR_RAW:    rdata_d[NC-1:0] = error_raw_status;    // [R5]
      dma_stat_pkg::ADDR_ENABLED:    rdata_d[NC-1:0] = enabled_channel_status; // [R6]
      dma_stat_pkg::ADDR_SOFT_BREQ:  rdata_d[NS-1:0] = software_burst_request; // [R11]
      dma_stat_pkg::ADDR_IRQ_MASK:   rdata_d[NE-1:0] = irq_mask_q;
      dma_stat_pkg::ADDR_IRQ_STAT:   rdata_d[NE-1:0] = irq_stat;
      dma_stat_pkg::ADDR_CH_ENABLE:  rdata_d[NC-1:0] = ch_enable_q;
      default:                       rdata_d = dma_stat_pkg::RST_ZERO;
    endcase
  end

  // read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      rdata_q <= dma_stat_pkg::RST_ZERO;
    else if (RD)
      rdata_q <= rdata_d;
    else
      rdata_q <= dma_stat_pkg::RST_ZERO;
  end

  assign RDATA = rdata_q;
endmodule
`default_nettype wire

/* File: verification/dma_stat_props.sv */
// checker for the dma status block, watching top ports only
// bound onto dma_irq_status from the testbench top file
`timescale 1ns/10ps
`default_nettype none
module dma_stat_props (
  input wire logic        CLK_SYS,
  input wire logic        NRST,
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  TC_EVENT,
  input wire logic [1:0]  ERR_EVENT,
  input wire logic [1:0]  CH_DONE,
  input wire logic [4:0]  PERIPH_BREQ,
  input wire logic [4:0]  SRC_DONE,
  input wire logic [4:0]  BURST_REQ,
  input wire logic [1:0]  CH_ENABLE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // decoded accesses
  wire wsoft = WR && ADDR == dma_stat_pkg::ADDR_SOFT_BREQ;
  wire wen   = WR && ADDR == dma_stat_pkg::ADDR_CH_ENABLE;
  wire ctc   = WR && ADDR == dma_stat_pkg::ADDR_TC_CLEAR && WDATA[0];
  wire rtc   = RD && ADDR == dma_stat_pkg::ADDR_TC_RAW;
  wire rer   = RD && ADDR == dma_stat_pkg::ADDR_ERR_RAW;
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h00000000)
    else $error("read data not zero outside read");
  a_tc_set_raw: assert property (rtc && $past(TC_EVENT[0]) |=> RDATA[0])
    else $error("tc event not in raw status");
  a_err_set_raw: assert property (rer && $past(ERR_EVENT[1]) |=> RDATA[1])
    else $error("error event not in raw status");
  a_tc_clear_raw: assert property (rtc && $past(ctc && !TC_EVENT[0]) |=> !RDATA[0])
    else $error("tc clear ignored");
  a_burst_or_line: assert property ((BURST_REQ & PERIPH_BREQ) == PERIPH_BREQ)
    else $error("peripheral request lost");
  a_burst_set: assert property ($past(wsoft) |-> (BURST_REQ & $past(WDATA[4:0])) == $past(WDATA[4:0]))
    else $error("software request not raised");
  a_burst_done: assert property ($past(|SRC_DONE && !wsoft)
    |-> (BURST_REQ & $past(SRC_DONE)) == (PERIPH_BREQ & $past(SRC_DONE)))
    else $error("request not dropped on done");
  a_chan_done: assert property ($past(CH_DONE[0]) |-> !CH_ENABLE[0])
    else $error("enable kept after done");
  a_chan_write: assert property ($past(wen && CH_DONE == 2'h0) |-> CH_ENABLE == $past(WDATA[1:0]))
    else $error("enable write not taken");
  c_src_done: cover property (|SRC_DONE);
  c_periph: cover property (|PERIPH_BREQ);
  c_ch_done: cover property (CH_DONE[0]);
endmodule
`default_nettype wire

/* File: verification/xfer_engine_model.sv */
// transfer engine stand-in: serves burst requests after a set delay
// expects the block's burst request output and a delay from the bench
`timescale 1ns/10ps
`default_nettype none
module xfer_engine_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [4:0] burst_req,
  input  wire logic [7:0] lat,
  output logic      [4:0] src_done,
  output logic      [1:0] tc_event,
  output logic      [1:0] ch_done
);
  logic [8:0] cnt_q;
  // wait lat cycles, pulse completion, then cool down a cycle
  always_ff @(posedge clk)
  begin
    src_done <= 5'h00;
    tc_event <= 2'h0;
    ch_done  <= 2'h0;
    if (!nrst)
      cnt_q <= 9'h000;
    else if (cnt_q == 9'h000)
      cnt_q <= (|burst_req) ? {1'b0, lat} + 9'h002 : 9'h000;
    else
    begin
      cnt_q <= cnt_q - 9'h001;
      if (cnt_q == 9'h002)
      begin
        src_done <= burst_req;
        tc_event <= {1'b0, |burst_req};
        ch_done  <= {1'b0, |burst_req};
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the dma status block and engine model
// expects dma_stat_pkg, dma_irq_status, the model and the checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top;
  logic        clk, nrst, wr, rd, irq;
  logic [31:0] addr, wdata, rdata, r;
  logic [1:0]  tb_tc, m_tc, err_ev, ch_done, ch_en, tm, em, et, ee, t, e;
  logic [4:0]  periph, src_done, breq;
  logic [7:0]  lat;
  int          error_cnt, checks_done, cyc, seed;
  wire  [1:0]  tc_all = tb_tc | m_tc;
  logic [31:0] ra [8] = '{dma_stat_pkg::ADDR_COMBINED, dma_stat_pkg::ADDR_TC_MASKED,
    dma_stat_pkg::ADDR_ERR_MASKED, dma_stat_pkg::ADDR_TC_RAW, dma_stat_pkg::ADDR_ERR_RAW,
    dma_stat_pkg::ADDR_ENABLED, dma_stat_pkg::ADDR_SOFT_BREQ, 32'hFFE04050};
  dma_irq_status dma_irq_status_i (.CLK_SYS(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .TC_EVENT(tc_all), .ERR_EVENT(err_ev), .CH_DONE(ch_done),
    .TC_MASK(tm), .ERR_MASK(em), .PERIPH_BREQ(periph), .SRC_DONE(src_done), .BURST_REQ(breq),
    .CH_ENABLE(ch_en), .IRQ(irq));
  xfer_engine_model xfer_engine_model_i (.clk(clk), .nrst(nrst), .burst_req(breq), .lat(lat),
    .src_done(src_done), .tc_event(m_tc), .ch_done(ch_done));
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run;
    end
  end
  function automatic logic [31:0] msk(input logic [1:0] a, input logic [1:0] m);
    return {30'h0, a & m};
  endfunction
  // one bus cycle, strobe left up for back-to-back use
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] dt);
    @(posedge clk);
    {wr, rd, tb_tc, err_ev} <= {w, ~w, 4'h0};
    addr <= a;
    wdata <= dt;
  endtask
  task automatic idle;
    @(posedge clk);
    {wr, rd} <= 2'h0;
    #1;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] x, input string n);
    acc(1'b0, a, 32'h0);
    idle;
    `CHK(n, x, rdata)
  endtask
  task automatic ev(input logic [1:0] a, input logic [1:0] b, input logic [3:0] m);
    @(posedge clk);
    {wr, rd, tb_tc, err_ev, em, tm} <= {2'h0, a, b, m};
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {nrst, wr, rd, tb_tc, err_ev, tm, em, et, ee, periph, addr, wdata} = '0;
    seed = 18;
    lat = 8'h04;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    foreach (ra[i]) rchk(ra[i], 32'h0, "reset");
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      {t, e} = (i == 0) ? 4'hF : r[3:0];
      ev(t, 2'h0, r[7:4]);
      et |= t;
      rchk(dma_stat_pkg::ADDR_TC_RAW, {30'h0, et}, "tc raw");
      ev(2'h0, e, r[7:4]);
      ee |= e;
      rchk(dma_stat_pkg::ADDR_ERR_RAW, {30'h0, ee}, "err raw");
      rchk(dma_stat_pkg::ADDR_TC_MASKED, msk(et, tm), "tc masked");
      rchk(dma_stat_pkg::ADDR_ERR_MASKED, msk(ee, em), "err masked");
      rchk(dma_stat_pkg::ADDR_COMBINED, msk(et, tm) | msk(ee, em), "combined");
      acc(1'b1, dma_stat_pkg::ADDR_TC_CLEAR, {30'h0, r[9:8]});
      et &= ~r[9:8];
      rchk(dma_stat_pkg::ADDR_TC_RAW, {30'h0, et}, "tc clear");
      acc(1'b1, dma_stat_pkg::ADDR_ERR_CLEAR, {30'h0, r[11:10]});
      ee &= ~r[11:10];
      rchk(dma_stat_pkg::ADDR_ERR_RAW, {30'h0, ee}, "err clear");
    end
    // block interrupt: raise, mask, clear
    acc(1'b1, dma_stat_pkg::ADDR_IRQ_MASK, 32'h1);
    idle;
    `CHK("irq on", 1'b1, irq)
    acc(1'b1, dma_stat_pkg::ADDR_IRQ_MASK, 32'h0);
    idle;
    `CHK("irq masked", 1'b0, irq)
    acc(1'b1, dma_stat_pkg::ADDR_IRQ_MASK, 32'h3);
    acc(1'b1, dma_stat_pkg::ADDR_IRQ_STAT, 32'h3);
    idle;
    `CHK("irq clear", 1'b0, irq)
    // software burst request per source, served by the engine
    for (int i = 0; i < 5; i++)
    begin
      r = $random(seed);
      lat = 8'h04 + {5'h0, r[2:0]};
      acc(1'b1, dma_stat_pkg::ADDR_CH_ENABLE, 32'h3);
      acc(1'b1, dma_stat_pkg::ADDR_SOFT_BREQ, 32'h1 << i);
      idle;
      `CHK("soft set", 5'h01 << i, breq)
      acc(1'b1, dma_stat_pkg::ADDR_SOFT_BREQ, 32'h0);
      rchk(dma_stat_pkg::ADDR_SOFT_BREQ, 32'h1 << i, "soft hold");
      rchk(dma_stat_pkg::ADDR_ENABLED, 32'h3, "enabled");
      for (int j = 0; j < 40 && src_done == 5'h00; j++) @(posedge clk) #1;
      @(posedge clk) #1;
      `CHK("soft done", 5'h00, breq)
      `CHK("ch done", 2'h2, ch_en)
    end
    acc(1'b1, dma_stat_pkg::ADDR_SOFT_BREQ, 32'hFFFFFFE0);
    rchk(dma_stat_pkg::ADDR_SOFT_BREQ, 32'h0, "reserved");
    // peripheral line alone, no software request meanwhile
    lat = 8'hC8;
    r = $random(seed);
    @(posedge clk) periph <= r[4:0] | 5'h01;
    rchk(dma_stat_pkg::ADDR_SOFT_BREQ, {27'h0, r[4:0] | 5'h01}, "periph");
    complete_run;
  end
endmodule
bind dma_irq_status dma_stat_props dma_stat_props_i (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TC_EVENT(TC_EVENT),
  .ERR_EVENT(ERR_EVENT), .CH_DONE(CH_DONE), .PERIPH_BREQ(PERIPH_BREQ),
  .SRC_DONE(SRC_DONE), .BURST_REQ(BURST_REQ), .CH_ENABLE(CH_ENABLE));
`default_nettype wire
